// ### inc/tpv_regs.svh
// Register offsets, field positions, reset values and trap vector constants
`ifndef TPV_REGS_SVH
`define TPV_REGS_SVH

// ==========================================
// Register byte offsets
`define TPV_OFF_REQ        12'h000
`define TPV_OFF_STATUS     12'h004
`define TPV_OFF_CTRL       12'h008
`define TPV_OFF_VECTOR     12'h00C
`define TPV_OFF_IRQ_STAT   12'h010
`define TPV_OFF_IRQ_MASK   12'h014

// ==========================================
// Control register fields
`define TPV_CTRL_FILE_ADAPTER  0
`define TPV_CTRL_SUPPRESS      1
`define TPV_CTRL_RESET         2'h0

// ==========================================
// Status byte fields
`define TPV_SYS_RETRY_BIT      1
`define TPV_SYS_MCHK_BIT       2

// ==========================================
// Trap vector bases
`define TPV_VEC_MCHK       16'hD000
`define TPV_VEC_MCHK_IO    16'hD010
`define TPV_VEC_RETRY      16'hD200
`define TPV_VEC_CPU_HIGH   16'hD300
`define TPV_VEC_ADAPTER    16'hD120
`define TPV_VEC_SEL_IFA    16'hD100
`define TPV_VEC_MUX        16'hD400
`define TPV_VEC_ADP_RET    16'hD480
`define TPV_VEC_STORE_DSP  16'hD840
`define TPV_VEC_CPU_LOW    16'hD800
`define TPV_VEC_SINGLE     16'hDC00

// ==========================================
// Response codes
`define TPV_RESP_OKAY      2'h0
`define TPV_RESP_SLVERR    2'h2

`endif

// ### inc/tpv_pkg.sv
// Types shared by the trap priority and vectoring block
package tpv_pkg;
    typedef logic [7:0]  tpv_req_t;    // One bit per trap source
    typedef logic [15:0] tpv_addr_t;   // Control storage address
    typedef logic [1:0]  tpv_sub_t;    // Sub-condition select
    typedef enum logic [1:0] {
        TPV_LOW_NONE,
        TPV_LOW_PROTECT,
        TPV_LOW_ADDR_CHECK,
        TPV_LOW_ADJUST
    } tpv_low_t;
endpackage

// ### inc/tpv_vec_if.sv
// Interface carrying the selected trap from the vector encoder
`timescale 1ns/1ps
interface tpv_vec_if;
    import tpv_pkg::*;
    logic      take;     // A trap is selected this cycle
    tpv_addr_t addr;     // Its vector address
    logic [2:0] source;  // Request bit selected
    modport enc (output take, output addr, output source);
    modport top (input take, input addr, input source);
endinterface

// ### rtl/tpv_vector_enc.sv
// Combinational priority and vector encoder for pending trap requests
`timescale 1ns/1ps
module tpv_vector_enc (
    input  tpv_pkg::tpv_req_t  pending,
    input  tpv_pkg::tpv_req_t  held,
    input  tpv_pkg::tpv_sub_t  subSel [8],
    input  wire logic          mchkWithIo,
    input  wire logic [7:0]    statusByte,
    input  wire logic          fileAdapter,
    input  wire logic          suppressAll,
    tpv_vec_if.enc             vec
);
    import tpv_pkg::*;
`include "tpv_regs.svh"

    // ==========================================
    // Blocking mask derived from held request bits
    function automatic tpv_req_t block_mask(input tpv_req_t h);
        tpv_req_t m;
        m = 8'h00;
        if (h[1]) m = m | 8'hFC;
        if (h[2]) m = m | 8'h04;
        if (h[3]) m = m | 8'h78;
        if (h[4]) m = m | 8'h70;
        if (h[5]) m = m | 8'h60;
        if (h[6]) m = m | 8'h40;
        if (h[7]) m = m | 8'h80;
        return m;
    endfunction

    // Base plus four times a sub-condition
    function automatic tpv_addr_t offs(input tpv_addr_t b, input tpv_sub_t s);
        return b + {12'h000, s, 2'b00};
    endfunction

    tpv_req_t live;   // Requests that may be taken

    // ==========================================
    // Priority select and vector build
    always_comb begin
        live = pending & ~block_mask(held)
               & (fileAdapter ? 8'hFF : 8'hEF);
        vec.take = 1'b0;
        vec.addr = 16'h0000;
        vec.source = 3'h0;
        if (!suppressAll) begin
            for (int i = 7; i >= 0; i--) begin
                if (live[i]) begin
                    vec.take = 1'b1;
                    vec.source = 3'(i);
                end
            end
        end
        unique case (vec.source)
            3'h0: begin
                vec.addr = offs(mchkWithIo ? `TPV_VEC_MCHK_IO : `TPV_VEC_MCHK,
                    {statusByte[`TPV_SYS_MCHK_BIT], held[0]});
            end
            3'h1: begin
                vec.addr = offs(`TPV_VEC_RETRY,
                    {statusByte[`TPV_SYS_RETRY_BIT], held[1]});
            end
            3'h2: vec.addr = offs(`TPV_VEC_CPU_HIGH, subSel[2]);
            3'h3: vec.addr = offs(`TPV_VEC_ADAPTER, subSel[3]);
            3'h4: vec.addr = offs(`TPV_VEC_SEL_IFA, subSel[4]);
            3'h5: vec.addr = `TPV_VEC_MUX;
            3'h6: vec.addr = offs(`TPV_VEC_ADP_RET, subSel[6]);
            3'h7: vec.addr = `TPV_VEC_STORE_DSP;
        endcase
    end
endmodule

// ### rtl/tpv_trap_ctrl.sv
// Trap request register, priority vectoring and AXI4-Lite register slave
// Behaviour
// - Machine check vectors by I/O, held bit and status
// - Retry vectors base, plus four, plus twelve
// - Retry during retry operation goes base+8
// - CPU-high sub-conditions map to four vectors
// - File adapter sub-conditions map to vectors
// - No adapter: selector channels use bit three
// - Adapter present: selectors use bit four
// - CPU-low faults vector to fixed offsets
// - Single-cycle or soft compare vectors fixed
// - Held request bits block lower requests; in the code held 0 and 2 block none below and 3-6 do not block 7
// - Suppress line stops every trap taken
//
// Added by the designer: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module tpv_trap_ctrl #(
    parameter int ADDR_W = 12
) (
    input  wire logic            sys_clk,
    input  wire logic            rst_b,
    // Requesters
    input  tpv_pkg::tpv_req_t    reqIn,
    input  wire logic [15:0]     reqSub,
    input  wire logic            mchkWithIo,
    input  tpv_pkg::tpv_low_t    cpuLowFault,
    input  wire logic            cpuLowWithIo,
    input  wire logic            singleCycleIo,
    input  wire logic            softCompareMatch,
    input  wire logic            suppressLine,
    // Sequencer side
    input  tpv_pkg::tpv_req_t    trapDone,
    output logic                 trapTake,
    output tpv_pkg::tpv_addr_t   trapAddr,
    output logic                 irq,
    // AXI4-Lite slave
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic            s_axi_awvalid,
    output logic                 s_axi_awready,
    input  wire logic [31:0]     s_axi_wdata,
    input  wire logic [3:0]      s_axi_wstrb,
    input  wire logic            s_axi_wvalid,
    output logic                 s_axi_wready,
    output logic [1:0]           s_axi_bresp,
    output logic                 s_axi_bvalid,
    input  wire logic            s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic            s_axi_arvalid,
    output logic                 s_axi_arready,
    output logic [31:0]          s_axi_rdata,
    output logic [1:0]           s_axi_rresp,
    output logic                 s_axi_rvalid,
    input  wire logic            s_axi_rready
);
    import tpv_pkg::*;
`include "tpv_regs.svh"

    // Upper address bits above the map must exist for the range check
    if (ADDR_W < 6) begin : g_addr_check
        $error("ADDR_W too small for register map");
    end

    // ==========================================
    // State
    tpv_req_t   held;            // Requests being serviced
    logic [7:0] statusByte;      // System status byte
    logic [1:0] ctrl;            // Adapter fitted, suppress
    logic [2:0] irqStat;         // Trap, low trap, fixed trap events
    logic [2:0] irqMask;         // Interrupt enables
    tpv_sub_t   subSel [8];      // Per-source sub-condition
    tpv_vec_if  vec ();          // Encoder result
    logic       lowTake;         // CPU-low trap this cycle
    logic       fixTake;         // Fixed-address trap this cycle
    logic       suppress;        // Any suppress source
    logic       awHeld;          // Write address captured
    logic       wHeld;           // Write data captured
    logic [ADDR_W-1:0] awAddr;   // Captured write address
    logic [31:0] wData;          // Captured write data
    logic [3:0] wStrb;           // Captured strobes
    logic       doWrite;         // Both halves present

    always_comb begin
        for (int i = 0; i < 8; i++) subSel[i] = reqSub[2*i +: 2];
    end

    assign suppress = suppressLine | ctrl[`TPV_CTRL_SUPPRESS];
    assign lowTake = !suppress && cpuLowFault != TPV_LOW_NONE
                     && !(cpuLowWithIo && cpuLowFault == TPV_LOW_ADJUST);
    assign fixTake = !suppress && (singleCycleIo | softCompareMatch);
    assign doWrite = awHeld && wHeld && !s_axi_bvalid;

    // Write strike on one register; upper address bits must be clear
    function automatic logic wr_hit(input logic [11:0] off);
        return doWrite && wStrb[0] && awAddr[ADDR_W-1:5] == '0 && awAddr[4:0] == off[4:0];
    endfunction

    // ==========================================
    // Encoder
    tpv_vector_enc u_enc (
        .pending     (reqIn),
        .held        (held),
        .subSel      (subSel),
        .mchkWithIo  (mchkWithIo),
        .statusByte  (statusByte),
        .fileAdapter (ctrl[`TPV_CTRL_FILE_ADAPTER]),
        .suppressAll (suppress),
        .vec         (vec)
    );

    // ==========================================
    // Request register: set on take, cleared by sequencer
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            held <= 8'h00;
        end else begin
            held <= (held & ~trapDone)
                    | (vec.take ? tpv_req_t'(8'h01 << vec.source) : 8'h00);
        end
    end

    // ==========================================
    // Vector output; request bits win over low and fixed traps
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            trapTake <= 1'b0;
            trapAddr <= 16'h0000;
        end else begin
            trapTake <= vec.take | lowTake | fixTake;
            if (vec.take) begin
                trapAddr <= vec.addr;
            end else if (lowTake) begin
                trapAddr <= `TPV_VEC_CPU_LOW
                    + {11'h000, cpuLowWithIo, cpuLowFault, 2'b00};
            end else if (fixTake) begin
                trapAddr <= `TPV_VEC_SINGLE;
            end
        end
    end

    // ==========================================
    // Status byte: hardware sets machine-check and retry flags
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            statusByte <= 8'h00;
        end else begin
            if (wr_hit(`TPV_OFF_STATUS)) begin
                statusByte <= wData[7:0];
            end
            if (vec.take && vec.source == 3'h0) begin
                statusByte[`TPV_SYS_MCHK_BIT] <= 1'b1;
            end
            if (vec.take && vec.source == 3'h1) begin
                statusByte[`TPV_SYS_RETRY_BIT] <= 1'b1;
            end
        end
    end

    // ==========================================
    // Control register
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            ctrl <= `TPV_CTRL_RESET;
        end else if (wr_hit(`TPV_OFF_CTRL)) begin
            ctrl <= wData[1:0];
        end
    end

    // ==========================================
    // Interrupt status, set wins over write-one clear
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            irqStat <= 3'h0;
            irqMask <= 3'h0;
        end else begin
            if (wr_hit(`TPV_OFF_IRQ_MASK)) begin
                irqMask <= wData[2:0];
            end
            irqStat <= (irqStat
                & ~(wr_hit(`TPV_OFF_IRQ_STAT) ? wData[2:0] : 3'h0))
                | {fixTake, lowTake, vec.take};
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) irq <= 1'b0;
        else irq <= |(irqStat & irqMask);
    end

    // ==========================================
    // AXI write channel: address and data in any order
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            awAddr <= '0;
            wData <= 32'h0000_0000;
            wStrb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `TPV_RESP_OKAY;
        end else begin
            s_axi_awready <= !awHeld && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !wHeld && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld <= 1'b1;
                awAddr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld <= 1'b1;
                wData <= s_axi_wdata;
                wStrb <= s_axi_wstrb;
            end
            if (doWrite) begin
                awHeld <= 1'b0;
                wHeld <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (awAddr[ADDR_W-1:5] == '0 && awAddr[1:0] == 2'b00
                    && (awAddr[4:0] == `TPV_OFF_STATUS || awAddr[4:0] == `TPV_OFF_CTRL
                     || awAddr[4:0] == `TPV_OFF_IRQ_STAT
                     || awAddr[4:0] == `TPV_OFF_IRQ_MASK))
                    ? `TPV_RESP_OKAY : `TPV_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ==========================================
    // AXI read channel
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `TPV_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `TPV_RESP_OKAY;
                s_axi_rdata <= 32'h0000_0000;
                if (s_axi_araddr[ADDR_W-1:5] != '0) begin
                    s_axi_rresp <= `TPV_RESP_SLVERR;
                end else begin
                    unique case (s_axi_araddr[4:0])
                        `TPV_OFF_REQ:      s_axi_rdata <= {24'h0, held};
                        `TPV_OFF_STATUS:   s_axi_rdata <= {24'h0, statusByte};
                        `TPV_OFF_CTRL:     s_axi_rdata <= {30'h0, ctrl};
                        `TPV_OFF_VECTOR:   s_axi_rdata <= {15'h0, trapTake, trapAddr};
                        `TPV_OFF_IRQ_STAT: s_axi_rdata <= {29'h0, irqStat};
                        `TPV_OFF_IRQ_MASK: s_axi_rdata <= {29'h0, irqMask};
                        default:           s_axi_rresp <= `TPV_RESP_SLVERR;
                    endcase
                end
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ==========================================
    // Checks
    sequence s_mchk_taken;
        vec.take && vec.source == 3'h0;
    endsequence

    a_mchk_vector: assert property (@(posedge sys_clk) disable iff (!rst_b)
        s_mchk_taken |=> trapTake && trapAddr == ($past(mchkWithIo) ? 16'hD010 : 16'hD000)
            + {12'h000, $past(statusByte[`TPV_SYS_MCHK_BIT]), $past(held[0]), 2'b00})
        else $error("machine check vector out of range");

    a_retry_base: assert property (@(posedge sys_clk) disable iff (!rst_b)
        vec.take && vec.source == 3'h1 && !held[1] && !statusByte[1]
            |=> trapAddr == `TPV_VEC_RETRY)
        else $error("retry base vector wrong");

    a_retry_busy: assert property (@(posedge sys_clk) disable iff (!rst_b)
        vec.take && vec.source == 3'h1 && !held[1] && statusByte[1]
            |=> trapAddr == 16'hD208)
        else $error("retry in progress vector wrong");

    a_retry_blocks: assert property (@(posedge sys_clk) disable iff (!rst_b)
        held[1] |-> !(vec.take && vec.source >= 3'h2))
        else $error("retry bit failed to block");

    a_suppress_all: assert property (@(posedge sys_clk) disable iff (!rst_b)
        suppressLine |=> !trapTake)
        else $error("trap taken while suppressed");

    a_low_fixed: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !vec.take && lowTake && !cpuLowWithIo && cpuLowFault == TPV_LOW_PROTECT
            |=> trapAddr == 16'hD804)
        else $error("storage protect vector wrong");

    a_single_cycle: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !vec.take && !lowTake && fixTake |=> trapTake && trapAddr == 16'hDC00)
        else $error("fixed trap vector wrong");

    a_priority_low: assert property (@(posedge sys_clk) disable iff (!rst_b)
        vec.take |-> ((reqIn & ~(8'hFF << vec.source)) & ~held & 8'h01) == 8'h00
            || held != 8'h00)
        else $error("lower bit skipped");

    a_irq_level: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (irqStat & irqMask) != 3'h0 |=> irq)
        else $error("interrupt not raised");
endmodule

// ### testbench/tpv_seq_model.sv
// Sequencer model that finishes each taken trap after a delay
`timescale 1ns/1ps
module tpv_seq_model (
    input  wire logic          sys_clk,
    input  wire logic          rst_b,
    input  wire logic          trapTake,
    input  tpv_pkg::tpv_addr_t trapAddr,
    input  wire logic          ackOn,
    input  wire logic [3:0]    lag,
    input  tpv_pkg::tpv_req_t  doneIn,
    output tpv_pkg::tpv_req_t  trapDone
);
    import tpv_pkg::*;
    logic [3:0] count; // Cycles left in service
    tpv_req_t   owed;  // Source now in service
    // Source bit that a vector belongs to
    function automatic tpv_req_t srcOf(input tpv_addr_t a);
        case (a[11:4])
            8'h00, 8'h01: srcOf = 8'h01;
            8'h20: srcOf = 8'h02;
            8'h30: srcOf = 8'h04;
            8'h12: srcOf = 8'h08;
            8'h10: srcOf = 8'h10;
            8'h40: srcOf = 8'h20;
            8'h48: srcOf = 8'h40;
            8'h84: srcOf = 8'h80;
            default: srcOf = 8'h00;
        endcase
    endfunction
    // ==========================================
    // Finish pulse, forced by the bench or after the delay
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            count <= 4'h0;
            owed <= 8'h00;
            trapDone <= 8'h00;
        end else begin
            trapDone <= doneIn;
            if (ackOn && trapTake) begin
                count <= lag;
                owed <= srcOf(trapAddr);
            end else if (count != 4'h0) begin
                count <= count - 4'h1;
                if (count == 4'h1) begin
                    trapDone <= doneIn | owed;
                end
            end
        end
    end
endmodule

// ### testbench/trap_priority_vectoring_test.sv
// Self-checking bench for the trap priority and vectoring block
`timescale 1ns/1ps
`include "tpv_regs.svh"
module trap_priority_vectoring_test;
    import tpv_pkg::*;
    // ==========================================
    // Stimulus and observed signals
    logic        sys_clk = 1'b0;
    logic        rst_b = 1'b0;
    tpv_req_t    reqIn = '0;
    logic [15:0] reqSub = '0;
    logic        mchkWithIo = 1'b0;
    tpv_low_t    cpuLowFault = TPV_LOW_NONE;
    logic        cpuLowWithIo = 1'b0;
    logic        singleCycleIo = 1'b0;
    logic        softCompareMatch = 1'b0;
    logic        suppressLine = 1'b0;
    logic        ackOn = 1'b0;
    tpv_req_t    doneIn = '0;
    tpv_req_t    trapDone;
    logic        trapTake;
    tpv_addr_t   trapAddr;
    logic        irq;
    logic [11:0] awaddr = '0;
    logic        awvalid = 1'b0;
    logic [31:0] wdata = '0;
    logic        wvalid = 1'b0;
    logic [11:0] araddr = '0;
    logic        arvalid = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    int          mismatches = 0;
    int          comparisons = 0;

    always #2.5 sys_clk = ~sys_clk;

    tpv_trap_ctrl i_dut (.sys_clk(sys_clk), .rst_b(rst_b), .reqIn(reqIn), .reqSub(reqSub),
        .mchkWithIo(mchkWithIo), .cpuLowFault(cpuLowFault), .cpuLowWithIo(cpuLowWithIo),
        .singleCycleIo(singleCycleIo), .softCompareMatch(softCompareMatch),
        .suppressLine(suppressLine), .trapDone(trapDone), .trapTake(trapTake),
        .trapAddr(trapAddr), .irq(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1));

    tpv_seq_model i_seq (.sys_clk(sys_clk), .rst_b(rst_b), .trapTake(trapTake),
        .trapAddr(trapAddr), .ackOn(ackOn), .lag(4'h3), .doneIn(doneIn), .trapDone(trapDone));

    // ==========================================
    // Comparison, closing and bus tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Write one word, hold each channel until taken, check the response
    task automatic axiWr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        check(bresp, r);
    endtask
    // Read one word and check data and response
    task automatic axiRd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        check(rdata, d);
        check(rresp, r);
    endtask
    // Drop strobes, then look at the take one cycle after it was due
    task automatic settle(input logic took, input tpv_addr_t e);
        @(posedge sys_clk);
        reqIn <= '0;
        cpuLowFault <= TPV_LOW_NONE;
        singleCycleIo <= 1'b0;
        softCompareMatch <= 1'b0;
        @(posedge sys_clk);
        check(trapTake, took);
        if (took) check(trapAddr, e);
    endtask
    task automatic pulse(input tpv_req_t r, input logic took, input tpv_addr_t e);
        reqIn <= r;
        settle(took, e);
    endtask
    // Finish serviced traps and load the status byte
    task automatic prep(input logic [7:0] stat, input tpv_req_t done);
        doneIn <= done;
        @(posedge sys_clk);
        doneIn <= '0;
        axiWr(`TPV_OFF_STATUS, {24'h0, stat}, `TPV_RESP_OKAY);
    endtask

    // ==========================================
    // Scenarios
    // Normal, already held, status flag, both
    task automatic tStatus(input int b, input logic [7:0] flag, input tpv_addr_t base);
        for (int i = 0; i < 4; i++) begin
            prep(i[1] ? flag : 8'h00, i[0] ? 8'h00 : 8'hFF);
            pulse(8'(1 << b), 1'b1, base + 16'(4 * i));
        end
    endtask
    // Every sub-condition of one source
    task automatic tSub(input int b, input logic fit, input logic took, input tpv_addr_t base);
        axiWr(`TPV_OFF_CTRL, {31'h0, fit}, `TPV_RESP_OKAY);
        for (int s = 0; s < 4; s++) begin
            prep(8'h00, 8'hFF);
            reqSub <= 16'(s << (2 * b));
            pulse(8'(1 << b), took, base + 16'(4 * s));
        end
        reqSub <= '0;
    endtask
    // Traps without request bits, and their order
    task automatic tLow();
        for (int w = 0; w < 2; w++) begin
            for (int f = 1; f < 4 - w; f++) begin
                prep(8'h00, 8'hFF);
                cpuLowWithIo <= w[0];
                cpuLowFault <= tpv_low_t'(f);
                settle(1'b1, 16'hD800 + 16'(16 * w + 4 * f));
            end
        end
        cpuLowWithIo <= 1'b0;
        singleCycleIo <= 1'b1;
        settle(1'b1, 16'hDC00);
        softCompareMatch <= 1'b1;
        settle(1'b1, 16'hDC00);
        singleCycleIo <= 1'b1;
        cpuLowFault <= TPV_LOW_PROTECT;
        settle(1'b1, 16'hD804);
        cpuLowFault <= TPV_LOW_ADDR_CHECK;
        pulse(8'h80, 1'b1, 16'hD840);
    endtask
    // Held bits against later requests, adapter fitted
    task automatic tBlock();
        axiWr(`TPV_OFF_CTRL, 32'h1, `TPV_RESP_OKAY);
        prep(8'h00, 8'hFF);
        pulse(8'hFE, 1'b1, 16'hD200);
        pulse(8'h04, 1'b0, 16'h0);
        pulse(8'h80, 1'b0, 16'h0);
        pulse(8'h01, 1'b1, 16'hD000);
        prep(8'h00, 8'hFF);
        pulse(8'h08, 1'b1, 16'hD120);
        pulse(8'h10, 1'b0, 16'h0);
        pulse(8'h40, 1'b0, 16'h0);
        pulse(8'h80, 1'b1, 16'hD840);
        pulse(8'h04, 1'b1, 16'hD300);
        pulse(8'h04, 1'b0, 16'h0);
        prep(8'h00, 8'hFF);
        pulse(8'h10, 1'b1, 16'hD100);
        pulse(8'h20, 1'b0, 16'h0);
        pulse(8'h08, 1'b1, 16'hD120);
        prep(8'h00, 8'hFF);
        pulse(8'h20, 1'b1, 16'hD400);
        pulse(8'h40, 1'b0, 16'h0);
        pulse(8'h20, 1'b0, 16'h0);
        axiWr(`TPV_OFF_CTRL, 32'h0, `TPV_RESP_OKAY);
    endtask
    // Line stops a request and a fixed trap; control bit stops a request trap
    task automatic tSuppress();
        prep(8'h00, 8'hFF);
        suppressLine <= 1'b1;
        pulse(8'h01, 1'b0, 16'h0);
        singleCycleIo <= 1'b1;
        settle(1'b0, 16'h0);
        suppressLine <= 1'b0;
        axiWr(`TPV_OFF_CTRL, 32'h2, `TPV_RESP_OKAY);
        pulse(8'h01, 1'b0, 16'h0);
        axiWr(`TPV_OFF_CTRL, 32'h0, `TPV_RESP_OKAY);
        pulse(8'h01, 1'b1, 16'hD000);
    endtask
    // Interrupt set, masked, cleared; registers and unmapped place
    task automatic tRegs();
        prep(8'h00, 8'hFF);
        axiWr(`TPV_OFF_IRQ_MASK, 32'h0, `TPV_RESP_OKAY);
        axiWr(`TPV_OFF_IRQ_STAT, 32'h7, `TPV_RESP_OKAY);
        pulse(8'h02, 1'b1, 16'hD200);
        axiRd(`TPV_OFF_IRQ_STAT, 32'h1, `TPV_RESP_OKAY);
        check(irq, 1'b0);
        axiWr(`TPV_OFF_IRQ_MASK, 32'h1, `TPV_RESP_OKAY);
        repeat (2) @(posedge sys_clk);
        check(irq, 1'b1);
        axiWr(`TPV_OFF_IRQ_STAT, 32'h1, `TPV_RESP_OKAY);
        repeat (2) @(posedge sys_clk);
        check(irq, 1'b0);
        axiRd(`TPV_OFF_REQ, 32'h2, `TPV_RESP_OKAY);
        axiRd(`TPV_OFF_STATUS, 32'h2, `TPV_RESP_OKAY);
        axiRd(12'h018, 32'h0, `TPV_RESP_SLVERR);
        axiWr(12'h018, 32'h0, `TPV_RESP_SLVERR);
    endtask

    // ==========================================
    // Main sequence and watchdog
    initial begin
        repeat (16) @(posedge sys_clk);
        rst_b <= 1'b1;
        @(posedge sys_clk);
        tStatus(0, 8'h04, 16'hD000);
        tStatus(1, 8'h02, 16'hD200);
        prep(8'h00, 8'hFF);
        mchkWithIo <= 1'b1;
        pulse(8'h01, 1'b1, 16'hD010);
        mchkWithIo <= 1'b0;
        tSub(2, 1'b0, 1'b1, 16'hD300);
        tSub(3, 1'b1, 1'b1, 16'hD120);
        tSub(3, 1'b0, 1'b1, 16'hD120);
        tSub(4, 1'b0, 1'b0, 16'hD100);
        tSub(4, 1'b1, 1'b1, 16'hD100);
        tSub(6, 1'b0, 1'b1, 16'hD480);
        tLow();
        tBlock();
        tSuppress();
        tRegs();
        prep(8'h00, 8'hFF);
        ackOn <= 1'b1;
        pulse(8'h04, 1'b1, 16'hD300);
        repeat (8) @(posedge sys_clk);
        pulse(8'h04, 1'b1, 16'hD300);
        conclude();
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        mismatches++;
        conclude();
    end
endmodule
